/* inc/trdc_pkg.sv */
// Constants, bus carrier and state layout for the triple reload down-counter
package trdc_pkg;

  // Structure sizes
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned NUM_CNT = 3;
  localparam int unsigned ADDR_W  = 6;
  localparam int unsigned DATA_W  = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CNT0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CNT1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CNT2 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_PRE0 = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_PRE1 = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_PRE2 = 6'h20;

  // Field positions
  localparam int unsigned CTRL_SEL_LSB  = 8;
  localparam int unsigned CTRL_SEL_MSB  = 9;
  localparam int unsigned CTRL_PEND_LSB = 0;
  localparam int unsigned STAT_LSB      = 0;

  // Reset values and the decrement step
  localparam logic [CNT_W-1:0]   CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]   CNT_ONE  = 16'h0001;
  localparam logic [1:0]         SEL_RST  = 2'h0;
  localparam logic [NUM_CNT-1:0] MASK_RST = 3'h0;

  // Bus phase, one-hot
  typedef enum logic [1:0] {
    TRDC_BUS_IDLE   = 2'b01,
    TRDC_BUS_ANSWER = 2'b10
  } trdc_phase_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [3:0]        byteenable;
  } trdc_avs_req_t;

  // Whole state of the block
  typedef struct packed {
    trdc_phase_t                  phase;
    logic [DATA_W-1:0]            rdata;
    logic [1:0]                   sel;
    logic [NUM_CNT-1:0]           mask;
    logic [NUM_CNT-1:0]           status;
    logic [NUM_CNT-1:0]           pend;
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
    logic [NUM_CNT-1:0][CNT_W-1:0] pre;
    logic [NUM_CNT-1:0]           sync1;
    logic [NUM_CNT-1:0]           sync2;
    logic [NUM_CNT-1:0]           sync3;
    logic [NUM_CNT-1:0]           lvl;
  } trdc_state_t;

  localparam trdc_state_t ST_RST = '{
    phase:  TRDC_BUS_IDLE,
    rdata:  32'h0000_0000,
    sel:    SEL_RST,
    mask:   MASK_RST,
    status: 3'h0,
    pend:   3'h0,
    cnt:    {CNT_RST, CNT_RST, CNT_RST},
    pre:    {CNT_RST, CNT_RST, CNT_RST},
    sync1:  3'h0,
    sync2:  3'h0,
    sync3:  3'h0,
    lvl:    3'h0
  };

endpackage

/* rtl/trdc_top.sv */
// Three reloading 16-bit down-counters with pin sharing and an Avalon-MM slave
`timescale 1ns/100ps

// Register map, byte offsets
// 0x00 counter 0: read current count
// 0x00 counter 0: write pre-load, arm load
// 0x04 counter 1: read current count
// 0x04 counter 1: write pre-load, arm load
// 0x08 counter 2: read current count
// 0x08 counter 2: write pre-load, arm load
// 0x0c control: bits 9:8 pin select
// 0x0c control: bits 2:0 load armed, read only
// 0x10 status: bits 2:0 sticky zero flags
// 0x10 status: write one to clear
// 0x14 mask: bits 2:0, one lets a flag out
// 0x18 pre-load 0: no load armed on write
// 0x1c pre-load 1: no load armed on write
// 0x20 pre-load 2: no load armed on write
// Other offsets: read zero, write ignored
// Upper half of read data always zero

// Bus timing
// Request seen at edge E0 while idle
// Waitrequest high in the cycle before E0
// Waitrequest low in the cycle after E0
// Write lands at edge E1
// Read data captured at E0, taken at E1
// Exactly one wait cycle per transfer
// Back-to-back requests allowed after E1
// Byte lanes 0 and 1 cover 16-bit registers
// Lane 1 guards the pin select field
// Lane 0 guards status and mask

// Count timing
// One pulse per cycle of tick high
// Pin pulse three edges after the pin rises
// Armed load consumes one pulse, no flag
// Otherwise one step down per pulse
// Step to zero reloads at once
// Count value zero visible only after reset or with pre-load zero
// Period equals pre-load in pulses
// Pre-load zero wraps through ffff
// Pre-load zero thus gives the full range
// Write while armed only updates pre-load

// Why no immediate load
// Loading at the write would skew the period
// Loading on the pulse keeps one phase
// Software sees the new count one pulse late

// Why a register-bus read is harmless
// Counter only moves on a source pulse
// Read path just samples the stored count
// No read side effect on any counter

// Interrupt flags
// Zero flag set the cycle after the pulse
// Flag stays until acknowledge or write one
// Flag kept while masked
// Unmasking later shows an old flag
// New zero beats a clear in the same cycle
// Interrupt line is flags and mask, ored
// Acknowledge bit n clears flag n only

// Pin sharing
// Select 0: all pins to interrupt levels
// Select 1: pin three clocks counter 0
// Select 2: pins three, four clock 0, 1
// Select 3: all pins clock counters
// Owned pin shows an inactive level
// Unowned counter falls back to the tick
// Tick ignored while a pin owns a counter
// Pin edges ignored while not owned

// Synchroniser
// Two flops bring each pin into the clock
// Third flop only remembers the last level
// Edge taken from second and third flops
// Level outputs lag the pin by three edges

// Limitations
// Pin must stay high and low two cycles each
// Faster pins lose edges without warning
// Pin edge near a select change may be lost
// Select change does not arm a load
// Counts freeze while the clock is stopped

// Reset
// Asynchronous, active high
// Counters and pre-loads clear to zero
// Select, mask and flags clear to zero
// Read data and level outputs clear
// Waitrequest follows a pending request
// First request allowed after release

// Trade-offs
// One wait cycle keeps read data in flops
// Flags in one word keep clears atomic
// Single state record, one next-state block
// Per-channel loop keeps channels identical

module trdc_top
  import trdc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire trdc_pkg::trdc_avs_req_t avs_req,
  output logic [trdc_pkg::DATA_W-1:0] avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   timer_tick_clock,
  input  wire logic                   ext_input_three,
  input  wire logic                   ext_input_four,
  input  wire logic                   ext_input_five,
  input  wire logic [2:0]             irq_ack,
  output logic [2:0]                  counter_irq_pending,
  output logic                        irq,
  output logic                        irq_level_ten,
  output logic                        irq_level_eleven,
  output logic                        irq_level_twelve
);

  import trdc_pkg::*;

  trdc_state_t st_ff;
  trdc_state_t nxt_st;

  // Byte-lane merge for a 16-bit register
  function automatic logic [CNT_W-1:0] merge16(
    input logic [CNT_W-1:0]  old_v,
    input logic [DATA_W-1:0] wd,
    input logic [3:0]        be
  );
    logic [CNT_W-1:0] res;
    res = old_v;
    if (be[0])
    begin
      res[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // Offset of counter or pre-load register for a given channel
  function automatic logic [ADDR_W-1:0] cnt_ofs(input int unsigned idx);
    logic [ADDR_W-1:0] res;
    res = OFS_CNT2;
    case (idx)
      0: res = OFS_CNT0;
      1: res = OFS_CNT1;
      default: res = OFS_CNT2;
    endcase
    return res;
  endfunction

  function automatic logic [ADDR_W-1:0] pre_ofs(input int unsigned idx);
    logic [ADDR_W-1:0] res;
    res = OFS_PRE2;
    case (idx)
      0: res = OFS_PRE0;
      1: res = OFS_PRE1;
      default: res = OFS_PRE2;
    endcase
    return res;
  endfunction

  // Combinational helpers
  logic [NUM_CNT-1:0] pin_edge;
  logic [NUM_CNT-1:0] pin_owned;
  logic [NUM_CNT-1:0] src_pulse;
  logic [NUM_CNT-1:0] zero_evt;
  logic [NUM_CNT-1:0] stat_clr;
  logic [CNT_W-1:0]   dec_v;
  logic [DATA_W-1:0]  rd_mux;
  logic               wr_take;
  logic               req_any;

  // Next-state logic for the whole block
  always_comb
  begin
    nxt_st    = st_ff;
    pin_edge  = '0;
    pin_owned = '0;
    src_pulse = '0;
    zero_evt  = '0;
    stat_clr  = '0;
    dec_v     = CNT_RST;
    rd_mux    = '0;
    req_any   = avs_req.read | avs_req.write;
    wr_take   = avs_req.write & (st_ff.phase == TRDC_BUS_ANSWER);

    // Two-flop synchroniser; the third stage only serves edge detection
    nxt_st.sync1 = {ext_input_five, ext_input_four, ext_input_three};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    pin_edge     = st_ff.sync2 & ~st_ff.sync3;

    // Counters, one pass per channel
    for (int unsigned i = 0; i < NUM_CNT; i++)
    begin
      // Pin i belongs to counter i once the select code passes i
      pin_owned[i] = (st_ff.sel > 2'(i));
      // Source choice: own pin edge or tick; keeps edges resolvable
      src_pulse[i] = pin_owned[i] ? pin_edge[i] : timer_tick_clock;
      if (src_pulse[i])
      begin
        if (st_ff.pend[i])
        begin
          // Pending write enters only on this pulse
          nxt_st.cnt[i]  = st_ff.pre[i];
          nxt_st.pend[i] = 1'b0;
        end
        else
        begin
          dec_v = st_ff.cnt[i] - CNT_ONE;
          if (dec_v == CNT_RST)
          begin
            // Reload at zero; pre-load 0 then wraps through ffff
            nxt_st.cnt[i] = st_ff.pre[i];
            zero_evt[i]   = 1'b1;
          end
          else
          begin
            nxt_st.cnt[i] = dec_v;
          end
        end
      end
    end

    // Pins not owned by a counter feed the interrupt levels
    nxt_st.lvl = st_ff.sync2 & ~pin_owned;

    // Read data selection
    case (avs_req.address)
      OFS_CNT0: rd_mux = {16'h0000, st_ff.cnt[0]};
      OFS_CNT1: rd_mux = {16'h0000, st_ff.cnt[1]};
      OFS_CNT2: rd_mux = {16'h0000, st_ff.cnt[2]};
      OFS_PRE0: rd_mux = {16'h0000, st_ff.pre[0]};
      OFS_PRE1: rd_mux = {16'h0000, st_ff.pre[1]};
      OFS_PRE2: rd_mux = {16'h0000, st_ff.pre[2]};
      OFS_CTRL:
      begin
        rd_mux[CTRL_SEL_MSB:CTRL_SEL_LSB]             = st_ff.sel;
        rd_mux[CTRL_PEND_LSB+NUM_CNT-1:CTRL_PEND_LSB] = st_ff.pend;
      end
      OFS_STAT: rd_mux[STAT_LSB+NUM_CNT-1:STAT_LSB] = st_ff.status;
      OFS_MASK: rd_mux[STAT_LSB+NUM_CNT-1:STAT_LSB] = st_ff.mask;
      default:  rd_mux = '0;
    endcase

    // Bus phase: one wait cycle, then the answer cycle
    case (st_ff.phase)
      TRDC_BUS_IDLE:
      begin
        if (req_any)
        begin
          nxt_st.phase = TRDC_BUS_ANSWER;
          nxt_st.rdata = avs_req.read ? rd_mux : '0;
        end
      end
      TRDC_BUS_ANSWER:
      begin
        nxt_st.phase = TRDC_BUS_IDLE;
      end
      default:
      begin
        nxt_st.phase = TRDC_BUS_IDLE;
      end
    endcase

    // Register writes take effect at the answer edge only
    if (wr_take)
    begin
      for (int unsigned i = 0; i < NUM_CNT; i++)
      begin
        if (avs_req.address == cnt_ofs(i))
        begin
          // Write lands in pre-load; counter follows on next pulse
          nxt_st.pre[i]  = merge16(st_ff.pre[i], avs_req.writedata, avs_req.byteenable);
          nxt_st.pend[i] = 1'b1;
        end
        if (avs_req.address == pre_ofs(i))
        begin
          // Pre-load only: taken at the next reload, no forced load
          nxt_st.pre[i] = merge16(st_ff.pre[i], avs_req.writedata, avs_req.byteenable);
        end
      end
      if ((avs_req.address == OFS_CTRL) && avs_req.byteenable[1])
      begin
        nxt_st.sel = avs_req.writedata[CTRL_SEL_MSB:CTRL_SEL_LSB];
      end
      if ((avs_req.address == OFS_MASK) && avs_req.byteenable[0])
      begin
        nxt_st.mask = avs_req.writedata[STAT_LSB+NUM_CNT-1:STAT_LSB];
      end
      if ((avs_req.address == OFS_STAT) && avs_req.byteenable[0])
      begin
        stat_clr = avs_req.writedata[STAT_LSB+NUM_CNT-1:STAT_LSB];
      end
    end

    // Sticky requests: acknowledge or write-one clears, a new zero wins
    stat_clr      = stat_clr | irq_ack;
    nxt_st.status = (st_ff.status & ~stat_clr) | zero_evt;
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= ST_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Wait until the answer cycle; cheap and keeps read data registered
  assign avs_waitrequest = req_any & (st_ff.phase != TRDC_BUS_ANSWER);
  assign avs_readdata    = st_ff.rdata;

  // Requests kept pending even while masked, gated only at the output
  assign counter_irq_pending = st_ff.status;
  assign irq                 = |(st_ff.status & st_ff.mask);

  // Shared pins toward the interrupt controller
  assign irq_level_ten    = st_ff.lvl[0];
  assign irq_level_eleven = st_ff.lvl[1];
  assign irq_level_twelve = st_ff.lvl[2];

endmodule

/* bench/trdc_monitor.sv */
// Bus handshake and interrupt timing checks for the counter block
`timescale 1ns/100ps
module trdc_mon
(
  input wire logic                         ref_clk,
  input wire logic                         sys_rst,
  input wire trdc_pkg::trdc_avs_req_t      avs_req,
  input wire logic [trdc_pkg::DATA_W-1:0]  avs_readdata,
  input wire logic                         avs_waitrequest,
  input wire logic                         timer_tick_clock,
  input wire logic                         ext_input_three,
  input wire logic                         ext_input_four,
  input wire logic                         ext_input_five,
  input wire logic [2:0]                   irq_ack,
  input wire logic [2:0]                   counter_irq_pending,
  input wire logic                         irq,
  input wire logic                         irq_level_ten,
  input wire logic                         irq_level_twelve
);
  import trdc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Request present on the bus
  logic req;
  assign req = avs_req.read | avs_req.write;
  sequence s_wait; req && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest; endsequence
  sequence s_quiet; ({ext_input_three, ext_input_four, ext_input_five} == 3'h0)[*4]; endsequence
  property p_one_wait; s_wait |=> s_ans; endproperty
  property p_idle; !req |-> !avs_waitrequest; endproperty
  property p_rdhi; s_ans ##0 avs_req.read |-> avs_readdata[31:16] == 16'h0; endproperty
  property p_sticky;
    counter_irq_pending[0] && !irq_ack[0] && !avs_req.write |=> counter_irq_pending[0];
  endproperty
  property p_ack;
    s_quiet ##0 (irq_ack == 3'h7 && !timer_tick_clock) |=> counter_irq_pending == 3'h0;
  endproperty
  property p_irq; irq |-> counter_irq_pending != 3'h0; endproperty
  property p_lvl10; irq_level_ten |-> $past(ext_input_three, 3); endproperty
  property p_lvl12; irq_level_twelve |-> $past(ext_input_five, 3); endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("waitrequest longer than one cycle");
  a_idle: assert property (p_idle)
    else $error("waitrequest high with no request");
  a_rdhi: assert property (p_rdhi)
    else $error("read data upper half not zero");
  a_sticky: assert property (p_sticky)
    else $error("request dropped without acknowledge");
  a_ack: assert property (p_ack)
    else $error("acknowledge did not clear requests");
  a_irq: assert property (p_irq)
    else $error("irq high with nothing pending");
  a_lvl10: assert property (p_lvl10)
    else $error("level ten without its pin");
  a_lvl12: assert property (p_lvl12)
    else $error("level twelve without its pin");
endmodule

/* bench/trdc_host.sv */
// Bus master model standing in for the processor core
`timescale 1ns/100ps
module trdc_host
(
  input  wire logic                        ref_clk,
  output trdc_pkg::trdc_avs_req_t          avs_req,
  input  wire logic                        avs_waitrequest,
  input  wire logic [trdc_pkg::DATA_W-1:0] avs_readdata
);
  import trdc_pkg::*;
  // Bus idle from time zero
  initial avs_req = '0;
  // One transfer, held until waitrequest is sampled low, then released
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d,
                      output logic [DATA_W-1:0] q);
    @(posedge ref_clk);
    avs_req <= '{address: a, read: !w, write: w, writedata: {16'h0, d}, byteenable: 4'hf};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req <= '0;
  endtask
endmodule

/* bench/tb_trdc_top.sv */
// Self-checking bench for the triple reload down-counter
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
bind trdc_top trdc_mon u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .timer_tick_clock(timer_tick_clock), .ext_input_three(ext_input_three),
  .ext_input_four(ext_input_four), .ext_input_five(ext_input_five), .irq_ack(irq_ack),
  .counter_irq_pending(counter_irq_pending), .irq_level_ten(irq_level_ten),
  .irq_level_twelve(irq_level_twelve));
module tb_trdc_top;
  import trdc_pkg::*;
  logic              ref_clk, sys_rst, tick, irq, wq;
  logic [2:0]        pins, ack, pend, lv;
  logic [DATA_W-1:0] rdat, q;
  trdc_avs_req_t     req;
  int                fails, n_tests, cyc, n, m;
  trdc_host u_host (.ref_clk(ref_clk), .avs_req(req), .avs_waitrequest(wq), .avs_readdata(rdat));
  trdc_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_req(req), .avs_readdata(rdat),
    .avs_waitrequest(wq), .timer_tick_clock(tick), .ext_input_three(pins[0]),
    .ext_input_four(pins[1]), .ext_input_five(pins[2]), .irq_ack(ack),
    .counter_irq_pending(pend), .irq(irq), .irq_level_ten(lv[0]),
    .irq_level_eleven(lv[1]), .irq_level_twelve(lv[2]));
  // Count after load plus j pulses; zero pre-load wraps over the full range
  function automatic logic [15:0] f_cnt(logic [15:0] p, int j);
    int per;
    per = (p == 16'h0) ? 65536 : int'(p);
    return p - 16'(j % per);
  endfunction
  // Pass-through level seen for pin i under select s
  function automatic logic f_lvl(int s, int i, logic p);
    return (s > i) ? 1'b0 : p;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    u_host.xfer(1'b0, a, 16'h0, q);
    `CHK(q, {16'h0, e})
  endtask
  // Hold the tick high for k count pulses
  task automatic tk(input int k);
    @(posedge ref_clk) tick <= 1'b1;
    repeat (k) @(posedge ref_clk);
    tick <= 1'b0;
  endtask
  // Slow pin edge on all pins, well under half the clock rate
  task automatic pe();
    @(posedge ref_clk) pins <= 3'h7;
    repeat (3) @(posedge ref_clk);
    pins <= 3'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Cuts a hang short well past the expected run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      test_done();
    end
  end
  initial
  begin
    sys_rst = 1'b1; tick = 1'b0; pins = 3'h0; ack = 3'h0; fails = 0; n_tests = 0; cyc = 0;
    void'($urandom(78595));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(OFS_CTRL, 16'h0);
    rdc(OFS_STAT, 16'h0);
    rdc(OFS_MASK, 16'h0);
    rdc(6'h3c, 16'h0);
    rdc(OFS_CNT0, 16'h0);
    $display("test reset done");
    // Tick-driven count, reload at zero, masked request then acknowledge
    n = $urandom_range(9, 2);
    wr(OFS_CNT0, 16'(n));
    rdc(OFS_CNT0, 16'h0);
    rdc(OFS_PRE0, 16'(n));
    for (int j = 0; j <= n + 1; j++)
    begin
      tk(1);
      rdc(OFS_CNT0, f_cnt(16'(n), j));
    end
    rdc(OFS_CNT1, 16'h0 - 16'(n + 2));
    rdc(OFS_STAT, 16'h1);
    @(negedge ref_clk) `CHK(irq, 1'b0)
    wr(OFS_MASK, 16'h1);
    @(negedge ref_clk) `CHK(irq, 1'b1)
    @(posedge ref_clk) ack <= 3'h7;
    @(posedge ref_clk) ack <= 3'h0;
    @(negedge ref_clk) `CHK({irq, pend}, 4'h0)
    $display("test tick done");
    // Zero pre-load: request only after 65536 pulses past the load
    wr(OFS_CNT0, 16'h0);
    tk(65536);
    @(negedge ref_clk) `CHK(pend[0], 1'b0)
    tk(1);
    @(negedge ref_clk) `CHK(pend[0], 1'b1)
    wr(OFS_STAT, 16'h7);
    rdc(OFS_STAT, 16'h0);
    $display("test range done");
    // Every pin select: owned pins read inactive, others pass through
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_CTRL, 16'(s << 8));
      @(posedge ref_clk) pins <= 3'($urandom_range(7, 0));
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      for (int i = 0; i < 3; i++) `CHK(lv[i], f_lvl(s, i, pins[i]))
      rdc(OFS_CTRL, 16'(s << 8));
    end
    @(posedge ref_clk) pins <= 3'h0;
    repeat (4) @(posedge ref_clk);
    // Pin edges count counter 2, tick ignored while pins own all counters
    m = $urandom_range(9, 3);
    wr(OFS_CNT2, 16'(m));
    repeat (3) pe();
    tk(3);
    rdc(OFS_CNT2, f_cnt(16'(m), 2));
    `CHK(lv, 3'h0)
    $display("test pins done");
    test_done();
  end
endmodule
